// ### hdl/ssl_servo_status.sv
// servo sequence-signal and status output logic with an AXI4-Lite register slave
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module ssl_servo_status
   import ssl_pkg::*;
#(
   parameter int SPEED_W = THRESH_W
)
(
   // clock and power-up reset
   input wire logic clk_i,
   input wire logic rst_i,
   // sequence inputs, active low
   input wire logic forward_limit_input_n_i,
   input wire logic reverse_limit_input_n_i,
   input wire logic fault_clear_input_n_i,
   input wire logic forward_prohibit_input_n_i,
   input wire logic reverse_prohibit_input_n_i,
   input wire logic servo_on_n_i,
   // drive internal state
   input wire logic fault_detect_i,
   input wire logic prep_done_i,
   input wire logic main_power_i,
   input wire logic [SPEED_W-1:0] motor_speed_i,
   input wire logic index_mark_i,
   // pins and panel
   output logic fault_output_o,
   output logic [N_TERM-1:0] terminal_n_o,
   output logic mode_switch_o,
   output logic panel_rotation_o,
   output logic irq_o,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // =====================================================================
   // functions
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // active-low level for one terminal; unsupported codes stay off (high)
   function automatic logic term_level(input logic [CODE_W-1:0] code, input logic rot_n,
                                       input logic rdy_n, input logic idx_n,
                                       input logic ot_n);
      logic lvl;
      lvl = 1'b1;
      case (code)
         MAP_ROT: lvl = rot_n;
         MAP_READY: lvl = rdy_n;
         MAP_INDEX: lvl = idx_n;
         MAP_OT: lvl = ot_n;
         default: lvl = 1'b1;
      endcase
      return lvl;
   endfunction

   // =====================================================================
   // state
   logic [N_SYNC-1:0] sync_a, sync_b;
   logic [N_SYNC-1:0] raw_in;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic awready, next_awready, wready, next_wready;
   logic bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic [MODE_W-1:0] mode, next_mode;
   logic fwd_dis, next_fwd_dis, rev_dis, next_rev_dis;
   logic [THRESH_W-1:0] thresh, next_thresh;
   logic [N_TERM*CODE_W-1:0] map, next_map;
   logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
   logic fault, next_fault, rot, next_rot, ready, next_ready;
   logic ot, next_ot, idx, next_idx, mode_sw, next_mode_sw;
   logic [N_TERM-1:0] term_n, next_term_n;
   logic irq, next_irq;
   logic wr_en, panel_clr, clear_req, ot_now;
   logic [31:0] wr_val, status_word;

   assign raw_in = {servo_on_n_i, reverse_prohibit_input_n_i, forward_prohibit_input_n_i,
                    fault_clear_input_n_i, reverse_limit_input_n_i, forward_limit_input_n_i};

   // =====================================================================
   // input synchronisers, idle high so nothing looks active at power-up
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync_a <= '1;
         sync_b <= '1;
      end
      else
      begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   // =====================================================================
   // bus slave and registers
   assign wr_en = !awready && !wready && !bvalid;
   assign status_word = {26'h0, idx, mode_sw, ot, ready, rot, fault};

   always_comb
   begin
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_awready = awready;
      next_wready = wready;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_arready = arready;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_mode = mode;
      next_fwd_dis = fwd_dis;
      next_rev_dis = rev_dis;
      next_thresh = thresh;
      next_map = map;
      next_irq_mask = irq_mask;
      panel_clr = 1'b0;
      wr_val = 32'h0;
      if (s_axi_awvalid && awready)
      begin
         next_aw_addr = s_axi_awaddr;
         next_awready = 1'b0;
      end
      if (s_axi_wvalid && wready)
      begin
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
         next_wready = 1'b0;
      end
      if (wr_en)
      begin
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         case (aw_addr)
            REG_CTRL:
            begin
               wr_val = merge_strb({26'h0, rev_dis, fwd_dis, mode}, w_data, w_strb);
               next_mode = wr_val[CTRL_MODE_LSB +: MODE_W];
               next_fwd_dis = wr_val[CTRL_FWD_DIS];
               next_rev_dis = wr_val[CTRL_REV_DIS];
               panel_clr = w_strb[CTRL_PANEL_CLR/8] && w_data[CTRL_PANEL_CLR];
            end
            REG_THRESH:
            begin
               wr_val = merge_strb({20'h0, thresh}, w_data, w_strb);
               // out-of-range values saturate instead of wrapping
               if (wr_val[31:THRESH_W] != 20'h0 || wr_val[THRESH_W-1:0] > THRESH_MAX)
               begin
                  next_thresh = THRESH_MAX;
               end
               else
               begin
                  next_thresh = wr_val[THRESH_W-1:0];
               end
            end
            REG_MAP:
            begin
               wr_val = merge_strb({20'h0, map}, w_data, w_strb);
               next_map = wr_val[N_TERM*CODE_W-1:0];
            end
            REG_IRQ_STAT:
            begin
               wr_val = merge_strb(32'h0, w_data, w_strb);
            end
            REG_IRQ_MASK:
            begin
               wr_val = merge_strb({28'h0, irq_mask}, w_data, w_strb);
               next_irq_mask = wr_val[IRQ_W-1:0];
            end
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      if (bvalid && s_axi_bready)
      begin
         next_bvalid = 1'b0;
         next_awready = 1'b1;
         next_wready = 1'b1;
      end
      if (s_axi_arvalid && arready)
      begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: next_rdata = {26'h0, rev_dis, fwd_dis, mode};
            REG_THRESH: next_rdata = {20'h0, thresh};
            REG_MAP: next_rdata = {20'h0, map};
            REG_STATUS: next_rdata = status_word;
            REG_IRQ_STAT: next_rdata = {28'h0, irq_stat};
            REG_IRQ_MASK: next_rdata = {28'h0, irq_mask};
            default:
            begin
               next_rdata = 32'h0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      if (rvalid && s_axi_rready)
      begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0;
         mode <= MODE_RESET;
         fwd_dis <= 1'b0;
         rev_dis <= 1'b0;
         thresh <= THRESH_DEFAULT;
         map <= MAP_DEFAULT;
         irq_mask <= 4'h0;
      end
      else
      begin
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         mode <= next_mode;
         fwd_dis <= next_fwd_dis;
         rev_dis <= next_rev_dis;
         thresh <= next_thresh;
         map <= next_map;
         irq_mask <= next_irq_mask;
      end
   end

   // =====================================================================
   // status, events and pins
   assign clear_req = !sync_b[SI_CLR] || panel_clr;
   assign ot_now = (!fwd_dis && !sync_b[SI_FWD_PRO]) || (!rev_dis && !sync_b[SI_REV_PRO]);

   always_comb
   begin
      // detection wins over a clear in the same cycle
      next_fault = fault_detect_i || (fault && !clear_req);
      next_rot = {{(32-SPEED_W){1'b0}}, motor_speed_i} > {20'h0, thresh};
      next_ready = !sync_b[SI_SVON] && prep_done_i && !fault && main_power_i;
      next_ot = ot_now;
      next_idx = index_mark_i;
      next_mode_sw = (mode == MODE_SPD_A || mode == MODE_SPD_B || mode == MODE_SPD_C)
                     && sync_b[SI_FWD_LIM] && sync_b[SI_REV_LIM];
      for (int t = 0; t < N_TERM; t++)
      begin
         // over-travel pin is off (high) during over-travel, unlike the other three
         next_term_n[t] = term_level(map[t*CODE_W +: CODE_W], !rot, !ready, !idx, ot);
      end
      next_irq_stat = irq_stat;
      if (wr_en && aw_addr == REG_IRQ_STAT)
      begin
         next_irq_stat = irq_stat & ~wr_val[IRQ_W-1:0];
      end
      next_irq_stat[IRQ_FAULT] = next_irq_stat[IRQ_FAULT] || (next_fault && !fault);
      next_irq_stat[IRQ_OT] = next_irq_stat[IRQ_OT] || (next_ot && !ot);
      next_irq_stat[IRQ_ROT] = next_irq_stat[IRQ_ROT] || (next_rot && !rot);
      next_irq_stat[IRQ_INDEX] = next_irq_stat[IRQ_INDEX] || (next_idx && !idx);
      next_irq = |(next_irq_stat & irq_mask);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fault <= 1'b0;
         rot <= 1'b0;
         ready <= 1'b0;
         ot <= 1'b0;
         idx <= 1'b0;
         mode_sw <= 1'b0;
         term_n <= '1;
         irq_stat <= 4'h0;
         irq <= 1'b0;
      end
      else
      begin
         fault <= next_fault;
         rot <= next_rot;
         ready <= next_ready;
         ot <= next_ot;
         idx <= next_idx;
         mode_sw <= next_mode_sw;
         term_n <= next_term_n;
         irq_stat <= next_irq_stat;
         irq <= next_irq;
      end
   end

   assign fault_output_o = fault;
   assign terminal_n_o = term_n;
   assign mode_switch_o = mode_sw;
   assign panel_rotation_o = rot;
   assign irq_o = irq;
   assign s_axi_awready = awready;
   assign s_axi_wready = wready;
   assign s_axi_bresp = bresp;
   assign s_axi_bvalid = bvalid;
   assign s_axi_arready = arready;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
   assign s_axi_rvalid = rvalid;

endmodule

// ### hdl/ssl_pkg.sv
// constants, register map and field layout of the servo status output logic
// Contract
// - in speed combinations 4, 5 or 6, switch mode when both limit inputs are high
// - fault output low in normal state, high when an abnormal condition is detected
// - fault clear input low, after the cause is removed, clears the fault status
// - power-up reset clears any fault by itself
// - a front-panel fault clear request acts like the fault clear input
// - rotation output low while speed is above threshold, high while below
// - threshold spans 0 to 3000 rpm, defaults to 20, applies at once
// - rotation status is also shown to the front-panel unit
// - ready low only with servo on, preparation done, no fault, main power on
// - index output low while the motor passes the encoder index position
// - index and over-travel outputs reach a terminal only through output mapping
// - over-travel output high while a travel-prohibit condition is present, else low
// - config digit 1 disables forward prohibit input, digit 2 the reverse one
// - mapping code per terminal: 1 rotation, 2 ready, 5 index, 6 over-travel
package ssl_pkg;
   // =====================================================================
   // register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_THRESH = 8'h04;
   localparam logic [7:0] REG_MAP = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_IRQ_STAT = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;
   // =====================================================================
   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int MODE_W = 4;
   localparam int CTRL_FWD_DIS = 4;
   localparam int CTRL_REV_DIS = 5;
   localparam int CTRL_PANEL_CLR = 8;
   localparam logic [MODE_W-1:0] MODE_SPD_A = 4'h4;
   localparam logic [MODE_W-1:0] MODE_SPD_B = 4'h5;
   localparam logic [MODE_W-1:0] MODE_SPD_C = 4'h6;
   localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
   // =====================================================================
   // threshold and output mapping
   localparam int THRESH_W = 12;
   localparam logic [THRESH_W-1:0] THRESH_DEFAULT = 12'h014;
   localparam logic [THRESH_W-1:0] THRESH_MAX = 12'hBB8;
   localparam int N_TERM = 3;
   localparam int CODE_W = 4;
   localparam logic [CODE_W-1:0] MAP_ROT = 4'h1;
   localparam logic [CODE_W-1:0] MAP_READY = 4'h2;
   localparam logic [CODE_W-1:0] MAP_INDEX = 4'h5;
   localparam logic [CODE_W-1:0] MAP_OT = 4'h6;
   localparam logic [N_TERM*CODE_W-1:0] MAP_DEFAULT = 12'h021;
   // =====================================================================
   // status and interrupt bits
   localparam int ST_FAULT = 0;
   localparam int ST_ROT = 1;
   localparam int ST_READY = 2;
   localparam int ST_OT = 3;
   localparam int ST_MODE = 4;
   localparam int ST_INDEX = 5;
   localparam int IRQ_W = 4;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_OT = 1;
   localparam int IRQ_ROT = 2;
   localparam int IRQ_INDEX = 3;
   // =====================================================================
   // synchroniser lanes, all active low
   localparam int N_SYNC = 6;
   localparam int SI_FWD_LIM = 0;
   localparam int SI_REV_LIM = 1;
   localparam int SI_CLR = 2;
   localparam int SI_FWD_PRO = 3;
   localparam int SI_REV_PRO = 4;
   localparam int SI_SVON = 5;
   // =====================================================================
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### bench/ssl_host_model.sv
// far-side model: external sequence circuit and host motion controller
`timescale 1ns/10ps
module ssl_host_model
   import ssl_pkg::*;
(
   // clock
   input wire logic clk_i,
   // bench requests
   input wire logic pwr_req_i,
   input wire logic ot_watch_i,
   input wire logic [THRESH_W-1:0] spd_req_i,
   // block outputs
   input wire logic fault_i,
   input wire logic ot_n_i,
   // to the block
   output logic main_power_o,
   output logic [THRESH_W-1:0] speed_o
);
   // =====================================================================
   // power cut and motion stop
   logic cut;
   always_ff @(posedge clk_i)
   begin
      cut <= fault_i;
   end
   // one cycle late: the power relay trails the fault pin
   assign main_power_o = pwr_req_i & ~cut;
   assign speed_o = (ot_watch_i & ot_n_i) ? {THRESH_W{1'b0}} : spd_req_i;
endmodule

// ### bench/ssl_servo_status_asserts.sv
// concurrent checks on the servo status block ports
`timescale 1ns/10ps
module ssl_servo_status_asserts
   import ssl_pkg::*;
#(
   parameter int SPEED_W = THRESH_W
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pins
   input wire logic forward_limit_input_n_i,
   input wire logic fault_clear_input_n_i,
   input wire logic fault_detect_i,
   input wire logic [SPEED_W-1:0] motor_speed_i,
   input wire logic fault_output_o,
   input wire logic mode_switch_o,
   input wire logic panel_rotation_o,
   // bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // =====================================================================
   // sequence and status
   mode_off_a: assert property ((!forward_limit_input_n_i)[*4] |=> !mode_switch_o)
      else $error("mode switch active with forward limit on");
   fault_set_a: assert property (fault_detect_i |=> fault_output_o)
      else $error("fault output not raised");
   // the current and two past samples cover the two-flop synchroniser
   fault_hold_a: assert property (fault_output_o && fault_clear_input_n_i
      && $past(fault_clear_input_n_i) && $past(fault_clear_input_n_i, 2) && !s_axi_wvalid
      && s_axi_wready && $past(s_axi_wready) && $past(s_axi_wready, 2) |=> fault_output_o)
      else $error("fault dropped without a clear");
   rot_zero_a: assert property ((motor_speed_i == '0)[*3] |=> !panel_rotation_o)
      else $error("rotating at standstill");
   rot_max_a: assert property ((motor_speed_i > THRESH_MAX)[*3] |=> panel_rotation_o)
      else $error("not rotating above top threshold");
   // =====================================================================
   // register bus
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write response not held");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read data not held");
endmodule
bind ssl_servo_status ssl_servo_status_asserts #(.SPEED_W(SPEED_W)) u_ssl_servo_status_asserts (.*);

// ### bench/tb.sv
// self-checking bench for the servo status block
`timescale 1ns/10ps
module tb;
   import ssl_pkg::*;
   logic clk_i, rst_i, forward_limit_input_n_i, reverse_limit_input_n_i, servo_on_n_i;
   logic fault_clear_input_n_i, forward_prohibit_input_n_i, reverse_prohibit_input_n_i;
   logic fault_detect_i, prep_done_i, main_power_i, index_mark_i, pwr_req, ot_watch;
   logic [11:0] motor_speed_i, spd_req;
   logic fault_output_o, mode_switch_o, panel_rotation_o, irq_o;
   logic [2:0] terminal_n_o;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int bad_count, total_checks;
   ssl_servo_status u_ssl_servo_status (.*);
   ssl_host_model u_ssl_host_model (.clk_i(clk_i), .pwr_req_i(pwr_req),
      .ot_watch_i(ot_watch), .spd_req_i(spd_req), .fault_i(fault_output_o),
      .ot_n_i(terminal_n_o[2]), .main_power_o(main_power_i), .speed_o(motor_speed_i));
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // =====================================================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic pa, pw;
      n = 0;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while ((pa || pw || s_axi_bvalid !== 1'b1) && n < 40)
      begin
         @(posedge clk_i);
         n++;
         if (s_axi_awready === 1'b1) pa = 1'b0;
         if (s_axi_wready === 1'b1) pw = 1'b0;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      s_axi_bready <= 1'b0;
      chk("write done", 1, n < 40);
      chk("bresp", RESP_OKAY, s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int n;
      logic pa;
      n = 0;
      pa = 1'b1;
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while ((pa || s_axi_rvalid !== 1'b1) && n < 40)
      begin
         @(posedge clk_i);
         n++;
         if (s_axi_arready === 1'b1) pa = 1'b0;
         s_axi_arvalid <= pa;
      end
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", r, s_axi_rresp);
   endtask
   // =====================================================================
   // scenarios
   task automatic t_reset();
      chk("fault rst", 0, fault_output_o);
      chk("terms rst", 3'h7, terminal_n_o);
      rd(REG_THRESH, 32'h14, RESP_OKAY);
      rd(REG_MAP, 32'h21, RESP_OKAY);
      rd(8'h18, 32'h0, RESP_SLVERR);
   endtask
   task automatic t_ready();
      servo_on_n_i <= 1'b0;
      prep_done_i <= 1'b1;
      pwr_req <= 1'b1;
      w(6);
      chk("ready on", 0, terminal_n_o[1]);
      prep_done_i <= 1'b0;
      w(3);
      chk("ready prep", 1, terminal_n_o[1]);
      prep_done_i <= 1'b1;
   endtask
   task automatic t_fault();
      @(posedge clk_i);
      fault_detect_i <= 1'b1;
      @(posedge clk_i);
      fault_detect_i <= 1'b0;
      w(6);
      chk("fault", 1, fault_output_o);
      chk("ready flt", 1, terminal_n_o[1]);
      chk("power cut", 0, main_power_i);
      chk("irq masked", 0, irq_o);
      wr(REG_IRQ_MASK, 32'h1);
      w(3);
      chk("irq", 1, irq_o);
      wr(REG_IRQ_STAT, 32'h1);
      w(3);
      chk("irq clr", 0, irq_o);
      chk("fault held", 1, fault_output_o);
      fault_clear_input_n_i <= 1'b0;
      w(6);
      fault_clear_input_n_i <= 1'b1;
      chk("fault clr", 0, fault_output_o);
      // let the released clear leave the synchroniser, else it wipes the next fault
      w(3);
      fault_detect_i <= 1'b1;
      @(posedge clk_i);
      fault_detect_i <= 1'b0;
      w(4);
      chk("fault again", 1, fault_output_o);
      wr(REG_CTRL, 32'h100);
      w(4);
      chk("panel clr", 0, fault_output_o);
      rd(REG_CTRL, 32'h0, RESP_OKAY);
   endtask
   task automatic t_rot();
      wr(REG_THRESH, 32'h64);
      spd_req <= 12'h064;
      w(4);
      chk("rot equal", 1, terminal_n_o[0]);
      spd_req <= 12'h065;
      w(4);
      chk("rot above", 0, terminal_n_o[0]);
      chk("panel rot", 1, panel_rotation_o);
      wr(REG_THRESH, 32'hFA0);
      rd(REG_THRESH, 32'hBB8, RESP_OKAY);
      spd_req <= 12'hFFF;
      w(4);
      chk("rot top", 1, panel_rotation_o);
      spd_req <= 12'h000;
   endtask
   task automatic t_mode();
      for (int m = 0; m < 8; m++)
      begin
         wr(REG_CTRL, 32'(m));
         w(5);
         chk("mode sw", 32'(m >= 4 && m <= 6), mode_switch_o);
      end
      wr(REG_CTRL, 32'h5);
      forward_limit_input_n_i <= 1'b0;
      w(6);
      chk("mode lim", 0, mode_switch_o);
      forward_limit_input_n_i <= 1'b1;
      reverse_limit_input_n_i <= 1'b0;
      w(6);
      chk("mode rlim", 0, mode_switch_o);
      reverse_limit_input_n_i <= 1'b1;
      w(6);
      chk("mode back", 1, mode_switch_o);
   endtask
   task automatic t_ot();
      wr(REG_CTRL, 32'h0);
      wr(REG_MAP, 32'h621);
      ot_watch <= 1'b1;
      spd_req <= 12'hFFF;
      forward_prohibit_input_n_i <= 1'b0;
      w(6);
      chk("ot fwd", 1, terminal_n_o[2]);
      chk("host stop", 0, panel_rotation_o);
      wr(REG_CTRL, 32'h10);
      w(6);
      chk("ot fwd dis", 0, terminal_n_o[2]);
      reverse_prohibit_input_n_i <= 1'b0;
      w(6);
      chk("ot rev", 1, terminal_n_o[2]);
      wr(REG_CTRL, 32'h30);
      w(6);
      chk("ot both dis", 0, terminal_n_o[2]);
      wr(REG_MAP, 32'h521);
      index_mark_i <= 1'b1;
      w(4);
      chk("index", 0, terminal_n_o[2]);
      wr(REG_MAP, 32'h21);
      w(3);
      chk("no map", 1, terminal_n_o[2]);
      index_mark_i <= 1'b0;
   endtask
   task automatic t_power();
      fault_detect_i <= 1'b1;
      @(posedge clk_i);
      fault_detect_i <= 1'b0;
      w(1);
      chk("fault set", 1, fault_output_o);
      // power cycle: reset alone must drop the latched fault and restore defaults
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("fault pwr", 0, fault_output_o);
      chk("irq pwr", 0, irq_o);
      rd(REG_IRQ_MASK, 32'h0, RESP_OKAY);
      rd(REG_THRESH, 32'h14, RESP_OKAY);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // =====================================================================
   // main sequence and watchdog
   initial
   begin
      rst_i = 1'b1;
      {forward_limit_input_n_i, reverse_limit_input_n_i, fault_clear_input_n_i} = 3'h7;
      {forward_prohibit_input_n_i, reverse_prohibit_input_n_i, servo_on_n_i} = 3'h7;
      {fault_detect_i, prep_done_i, index_mark_i, pwr_req, ot_watch} = 5'h00;
      spd_req = 12'h000;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_ready();
      t_fault();
      t_rot();
      t_mode();
      t_ot();
      t_power();
      summarize();
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      summarize();
   end
endmodule
